// file: pwm_fault_auto_shutdown.sv
// file: auto-shutdown logic of a four-output pwm channel, apb slave
// Summary of operation
// - active enabled source sets event flag
// - flag holds until software or auto-restart
// - force enabled outputs immediately, no clock
// - a/c use bits 3:2, b/d bits 1:0
// - flag one means outputs held in shutdown
// - bits 6:4 select comparators and fault pin
// - a/c pair: 00 low, 01 high, 1x released
// - b/d pair: 00 low, 01 high, 1x released
// - shutdown is level based, persists while active
// - flag writes ignored while condition is active
// - outputs resume at next pwm period start
`timescale 1ns/1ps
`default_nettype none
module pwm_fault_auto_shutdown (
    input wire logic clk_sys,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // fault sources
    input wire logic comparator1_result,
    input wire logic comparator2_result,
    input wire logic fault_input_pin_n,
    // pwm generator side
    input wire logic pwm_a,
    input wire logic pwm_b,
    input wire logic pwm_c,
    input wire logic pwm_d,
    input wire logic period_start,
    // output pins, enables low while driven
    output logic pwm_out_a,
    output logic pwm_out_a_oe_n,
    output logic pwm_out_b,
    output logic pwm_out_b_oe_n,
    output logic pwm_out_c,
    output logic pwm_out_c_oe_n,
    output logic pwm_out_d,
    output logic pwm_out_d_oe_n,
    output logic irq
);
    // =========================================================
    // state
    // trade-off: one 8-bit control word, so a write to the state
    // fields also tries the flag bit; the flag half may be refused
    logic [7:0] control_reg; // bit 7 is the event flag
    logic [7:0] control_next;
    logic [1:0] irq_status_reg; // sticky events, cleared on read
    logic [1:0] irq_status_next;
    logic [1:0] irq_mask_reg;
    logic [1:0] irq_mask_next;
    logic auto_restart_reg; // clear flag by hardware when fault goes
    logic auto_restart_next;
    logic held_reg; // outputs held until a period start
    logic held_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // synchronised source levels
    logic cmp1_sync;
    logic cmp2_sync;
    logic fault_n_sync;
    logic cond_sync; // selected condition, clock domain
    logic cond_async; // selected condition, raw
    logic shutdown_now; // drives the override
    logic wr_access;
    logic rd_access;
    logic rd_setup; // read setup cycle, loads the read data flop

    // =========================================================
    // source select decode, used for raw and synchronised levels
    // select bits act as an or-mask, so the combined codes need
    // no table of their own
    function automatic logic source_active(
        input logic [2:0] sel,
        input logic c1,
        input logic c2,
        input logic flt_n
    );
        logic hit;
        hit = 1'b0;
        if ((sel & shutdown_pkg::src_cmp1) != 3'h0 && c1) begin
            hit = 1'b1;
        end
        if ((sel & shutdown_pkg::src_cmp2) != 3'h0 && c2) begin
            hit = 1'b1;
        end
        if ((sel & shutdown_pkg::src_fault) != 3'h0 && !flt_n) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // =========================================================
    // synchronisers for the three pins
    // the sources are not timed to this clock; two flops each keep
    // metastability out of the flag and status logic
    sync_two_stage sync_cmp1 (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in(comparator1_result),
        .sync_out(cmp1_sync)
    );
    sync_two_stage sync_cmp2 (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in(comparator2_result),
        .sync_out(cmp2_sync)
    );
    // reset value 0 would look like an active fault for two cycles;
    // invert around the synchroniser so reset means idle
    logic fault_sync_raw;
    sync_two_stage sync_fault (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in(!fault_input_pin_n),
        .sync_out(fault_sync_raw)
    );
    assign fault_n_sync = !fault_sync_raw;

    // =========================================================
    // condition levels
    // raw level for the pins, synchronised level for the registers
    always_comb begin
        cond_async = source_active(
            control_reg[shutdown_pkg::source_hi:shutdown_pkg::source_lo],
            comparator1_result, comparator2_result, fault_input_pin_n);
        cond_sync = source_active(
            control_reg[shutdown_pkg::source_hi:shutdown_pkg::source_lo],
            cmp1_sync, cmp2_sync, fault_n_sync);
    end

    // raw level forces at once; flag and hold keep it after it goes
    // limitation: a pulse shorter than one clock forces the pins
    // but may never reach the flag, so software can miss it
    assign shutdown_now = cond_async ||
        control_reg[shutdown_pkg::event_flag_bit] || held_reg;

    // =========================================================
    // apb decode: zero wait states, always ready
    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && penable && !pwrite;
    // setup cycle of a read: the read data flop is loaded here
    assign rd_setup = psel && !penable && !pwrite;
    // pready tied high: every transfer ends in its access cycle
    assign pready = 1'b1;

    // unmapped addresses answer with an error
    // only aligned word addresses are mapped; any other is an error
    always_comb begin
        if (paddr == shutdown_pkg::control_offset) begin
            pslverr = 1'b0;
        end else if (paddr == shutdown_pkg::irq_status_offset) begin
            pslverr = 1'b0;
        end else if (paddr == shutdown_pkg::irq_mask_offset) begin
            pslverr = 1'b0;
        end else if (paddr == shutdown_pkg::restart_offset) begin
            pslverr = 1'b0;
        end else begin
            pslverr = 1'b1;
        end
    end

    // =========================================================
    // next values for registers, flag and hold
    always_comb begin
        logic flag;
        logic set_event;
        logic resume_event;
        flag = control_reg[shutdown_pkg::event_flag_bit];
        control_next = control_reg;
        irq_mask_next = irq_mask_reg;
        auto_restart_next = auto_restart_reg;
        held_next = held_reg;
        irq_status_next = irq_status_reg;
        prdata_next = 32'h0;
        set_event = 1'b0;
        resume_event = 1'b0;
        // software writes; the flag bit only if condition gone
        if (wr_access) begin
            if (paddr == shutdown_pkg::control_offset) begin
                control_next[6:0] = pwdata[6:0];
                if (!cond_sync) begin
                    control_next[shutdown_pkg::event_flag_bit] =
                        pwdata[shutdown_pkg::event_flag_bit];
                end
            end else if (paddr == shutdown_pkg::irq_mask_offset) begin
                irq_mask_next = pwdata[1:0];
            end else if (paddr == shutdown_pkg::restart_offset) begin
                auto_restart_next = pwdata[shutdown_pkg::auto_restart_bit];
            end
        end
        // auto-restart clears the flag once the level is gone
        // without auto-restart only a software write clears the flag
        if (auto_restart_reg && flag && !cond_sync) begin
            control_next[shutdown_pkg::event_flag_bit] = 1'b0;
        end
        // hardware set wins over every clear
        // a clear in the same cycle as a fault loses; the fault is
        // still there, so the flag must stay
        if (cond_sync) begin
            control_next[shutdown_pkg::event_flag_bit] = 1'b1;
            set_event = !flag;
        end
        // a flag that falls leaves outputs held to the period edge
        // resuming mid period would send a runt pulse to the power
        // stage, so the hold waits for the next period start
        if (flag && !control_next[shutdown_pkg::event_flag_bit]) begin
            held_next = 1'b1;
        end else if (held_reg && period_start &&
                     !control_next[shutdown_pkg::event_flag_bit]) begin
            held_next = 1'b0;
            resume_event = 1'b1;
        end
        if (control_next[shutdown_pkg::event_flag_bit]) begin
            held_next = 1'b0;
        end
        // read data are taken in the setup cycle and stand in a flop
        // through the access cycle; zero wait states need no more
        if (rd_setup) begin
            if (paddr == shutdown_pkg::control_offset) begin
                prdata_next[7:0] = control_reg;
            end else if (paddr == shutdown_pkg::irq_status_offset) begin
                prdata_next[1:0] = irq_status_reg;
            end else if (paddr == shutdown_pkg::irq_mask_offset) begin
                prdata_next[1:0] = irq_mask_reg;
            end else if (paddr == shutdown_pkg::restart_offset) begin
                prdata_next[shutdown_pkg::auto_restart_bit] =
                    auto_restart_reg;
            end
        end
        // read-to-clear drops only the bits that the read reported;
        // an event that arrives between setup and access survives
        if (rd_access && paddr == shutdown_pkg::irq_status_offset) begin
            irq_status_next = irq_status_reg & ~prdata_reg[1:0];
        end
        // events set after the read clear so they are not lost
        if (set_event) begin
            irq_status_next[shutdown_pkg::irq_shutdown_bit] = 1'b1;
        end
        if (resume_event) begin
            irq_status_next[shutdown_pkg::irq_resume_bit] = 1'b1;
        end
    end

    // register everything
    // reset leaves shutdown disabled and no output held
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            control_reg <= shutdown_pkg::control_reset;
            irq_status_reg <= 2'h0;
            irq_mask_reg <= shutdown_pkg::irq_mask_reset;
            auto_restart_reg <= shutdown_pkg::auto_restart_reset;
            held_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            control_reg <= control_next;
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
            auto_restart_reg <= auto_restart_next;
            held_reg <= held_next;
            prdata_reg <= prdata_next;
        end
    end

    // read data straight from the flop; it is zero outside an access
    // because the flop is cleared at the edge that ends each read
    assign prdata = prdata_reg;

    // level interrupt: high while any unmasked sticky bit is set
    assign irq = |(irq_status_reg & irq_mask_reg);

    // =========================================================
    // pin pair overrides
    // both pairs share shutdown_now; only their state fields differ
    pair_override pair_ac (
        .shutdown_now(shutdown_now),
        .pss(control_reg[shutdown_pkg::ac_hi:shutdown_pkg::ac_lo]),
        .pwm_first(pwm_a),
        .pwm_second(pwm_c),
        .first_out(pwm_out_a),
        .first_oe_n(pwm_out_a_oe_n),
        .second_out(pwm_out_c),
        .second_oe_n(pwm_out_c_oe_n)
    );
    pair_override pair_bd (
        .shutdown_now(shutdown_now),
        .pss(control_reg[shutdown_pkg::bd_hi:shutdown_pkg::bd_lo]),
        .pwm_first(pwm_b),
        .pwm_second(pwm_d),
        .first_out(pwm_out_b),
        .first_oe_n(pwm_out_b_oe_n),
        .second_out(pwm_out_d),
        .second_oe_n(pwm_out_d_oe_n)
    );
endmodule
`default_nettype wire

// file: shutdown_pkg.sv
// package: register map, field layout, reset values and encodings
package shutdown_pkg;
    // =========================================================
    // register offsets (byte addresses on the register bus)
    localparam logic [7:0] control_offset = 8'h00;
    localparam logic [7:0] irq_status_offset = 8'h04;
    localparam logic [7:0] irq_mask_offset = 8'h08;
    localparam logic [7:0] restart_offset = 8'h0C;
    // =========================================================
    // control register fields
    localparam int event_flag_bit = 7;
    localparam int source_hi = 6;
    localparam int source_lo = 4;
    localparam int ac_hi = 3;
    localparam int ac_lo = 2;
    localparam int bd_hi = 1;
    localparam int bd_lo = 0;
    // restart register fields
    localparam int auto_restart_bit = 0;
    // =========================================================
    // reset values
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [1:0] irq_mask_reset = 2'h0;
    localparam logic auto_restart_reset = 1'b0;
    // interrupt status bits
    localparam int irq_shutdown_bit = 0;
    localparam int irq_resume_bit = 1;
    // =========================================================
    // source select encodings
    localparam logic [2:0] src_off = 3'h0;
    localparam logic [2:0] src_cmp1 = 3'h1;
    localparam logic [2:0] src_cmp2 = 3'h2;
    localparam logic [2:0] src_fault = 3'h4;
    // pair shutdown state encodings
    localparam logic [1:0] pss_low = 2'h0;
    localparam logic [1:0] pss_high = 2'h1;
endpackage

// file: sync_two_stage.sv
// file: two flip-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module sync_two_stage (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic async_in,
    output logic sync_out
);
    // =========================================================
    // synchroniser stages
    logic stage1_reg; // first stage, read only by the second
    logic stage1_next;
    logic stage2_reg;
    logic stage2_next;

    // next values: plain shift
    always_comb begin
        stage1_next = async_in;
        stage2_next = stage1_reg;
    end

    // register both stages
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign sync_out = stage2_reg;
endmodule
`default_nettype wire

// file: pair_override.sv
// file: combinational shutdown override for one pin pair
`timescale 1ns/1ps
`default_nettype none
module pair_override (
    input wire logic shutdown_now,
    input wire logic [1:0] pss,
    input wire logic pwm_first,
    input wire logic pwm_second,
    output logic first_out,
    output logic first_oe_n,
    output logic second_out,
    output logic second_oe_n
);
    // =========================================================
    // override: no clock in this path so the force is immediate
    always_comb begin
        first_out = pwm_first;
        second_out = pwm_second;
        first_oe_n = 1'b0;
        second_oe_n = 1'b0;
        if (shutdown_now) begin
            if (pss == shutdown_pkg::pss_low) begin
                first_out = 1'b0;
                second_out = 1'b0;
            end else if (pss == shutdown_pkg::pss_high) begin
                first_out = 1'b1;
                second_out = 1'b1;
            end else begin
                // 1x: release the pins, drive nothing
                first_out = 1'b0;
                second_out = 1'b0;
                first_oe_n = 1'b1;
                second_oe_n = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: fault_source_model.sv
// partner model: comparators, fault pin and a free-running pwm generator
`timescale 1ns/1ps
`default_nettype none
module fault_source_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [2:0] fault_cmd,
    output logic comparator1_result,
    output logic comparator2_result,
    output logic fault_input_pin_n,
    output logic pwm_a,
    output logic pwm_b,
    output logic pwm_c,
    output logic pwm_d,
    output logic period_start
);
    // ==========================================
    // period counter, eight cycles a period
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    // next count, wraps so period_start is a one-cycle pulse
    always_comb begin
        cnt_next = cnt_reg + 3'h1;
    end
    // register only
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= 3'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    // fault levels follow the command; the pin is low while in fault
    assign comparator1_result = fault_cmd[0];
    assign comparator2_result = fault_cmd[1];
    assign fault_input_pin_n = !fault_cmd[2];
    // distinct waveforms so a swapped pair shows up
    assign pwm_a = !cnt_reg[2];
    assign pwm_b = cnt_reg[2];
    assign pwm_c = cnt_reg[1];
    assign pwm_d = !cnt_reg[1];
    assign period_start = (cnt_reg == 3'h0);
endmodule
`default_nettype wire

// file: pwm_fault_auto_shutdown_props.sv
// checker: port-level assertions of the auto-shutdown block
`timescale 1ns/1ps
`default_nettype none
module shutdown_props (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic comparator1_result,
    input wire logic comparator2_result,
    input wire logic fault_input_pin_n,
    input wire logic period_start,
    input wire logic pwm_out_a,
    input wire logic pwm_out_a_oe_n,
    input wire logic pwm_out_b,
    input wire logic pwm_out_b_oe_n,
    input wire logic irq
);
    // ==========================================
    // shadow of control fields 6:0, the mask, and fault age
    logic [6:0] ctl_reg, ctl_next;
    logic [1:0] mask_reg, mask_next;
    logic [2:0] held_reg, held_next;
    logic wr_ok, rd_ctl, raw;
    assign wr_ok = psel && penable && pwrite && pready;
    assign rd_ctl = psel && penable && !pwrite && paddr == 8'h00;
    // raw level: flag bit is not shadowed, it can be refused
    assign raw = (ctl_reg[4] && comparator1_result) ||
        (ctl_reg[5] && comparator2_result) ||
        (ctl_reg[6] && !fault_input_pin_n);
    // next shadow values; age saturates at seven
    always_comb begin
        ctl_next = ctl_reg;
        mask_next = mask_reg;
        held_next = raw ? held_reg + {2'h0, held_reg != 3'h7} : 3'h0;
        if (wr_ok && paddr == shutdown_pkg::control_offset) begin
            ctl_next = pwdata[6:0];
        end
        if (wr_ok && paddr == shutdown_pkg::irq_mask_offset) begin
            mask_next = pwdata[1:0];
        end
    end
    // register only
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctl_reg <= 7'h00;
            mask_reg <= 2'h0;
            held_reg <= 3'h0;
        end else begin
            ctl_reg <= ctl_next;
            mask_reg <= mask_next;
            held_reg <= held_next;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_ac_state: assert property (raw |-> (ctl_reg[3] ? pwm_out_a_oe_n :
        (!pwm_out_a_oe_n && pwm_out_a == ctl_reg[2])))
        else $error("a/c pin not in shutdown state");
    a_bd_state: assert property (raw |-> (ctl_reg[1] ? pwm_out_b_oe_n :
        (!pwm_out_b_oe_n && pwm_out_b == ctl_reg[0])))
        else $error("b/d pin not in shutdown state");
    a_flag_sync: assert property ($rose(raw) && mask_reg[0] && !irq
        |=> !irq ##[0:4] irq) else $error("shutdown interrupt timing wrong");
    a_irq_masked: assert property (mask_reg == 2'h0 |-> !irq)
        else $error("interrupt raised while masked");
    a_flag_held: assert property (rd_ctl && held_reg == 3'h7
        |-> prdata[7]) else $error("event flag clear during fault");
    a_idle_rdata: assert property (!(psel && penable) |-> prdata == 32'h0)
        else $error("read data outside access");
    a_slverr_map: assert property (psel && penable |->
        pslverr == (paddr > shutdown_pkg::restart_offset))
        else $error("slave error does not match map");
    a_pready_high: assert property (psel |-> pready)
        else $error("wait state inserted");
    a_resume_period: assert property ($fell(pwm_out_a_oe_n) &&
        $past(ctl_reg[3]) && ctl_reg[3] && !raw |-> $past(period_start))
        else $error("outputs resumed mid period");
endmodule
bind pwm_fault_auto_shutdown shutdown_props props_u (.clk_sys(clk_sys),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comparator1_result(comparator1_result),
    .comparator2_result(comparator2_result),
    .fault_input_pin_n(fault_input_pin_n), .period_start(period_start),
    .pwm_out_a(pwm_out_a), .pwm_out_a_oe_n(pwm_out_a_oe_n),
    .pwm_out_b(pwm_out_b), .pwm_out_b_oe_n(pwm_out_b_oe_n), .irq(irq));
`default_nettype wire

// file: test_pwm_fault_auto_shutdown.sv
// testbench: table-driven source and pin-state cases, then hand tests
`timescale 1ns/1ps
`default_nettype none
module test_pwm_fault_auto_shutdown;
    // ==========================================
    // signals
    logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, irq;
    logic c1, c2, flt_n, pa, pb, pc, pd, pstart;
    logic oa, oa_n, ob, ob_n, oc, oc_n, od, od_n;
    logic [7:0] paddr, cfg;
    logic [31:0] pwdata, prdata, q;
    logic [2:0] fault_cmd;
    logic [10:0] r;
    logic e;
    int miscompares, checks_done;
    // rows: {select, a/c state, b/d state, fault cmd, trips}
    logic [10:0] rows [11] = '{{3'h0, 2'h0, 2'h0, 3'h7, 1'h0},
        {3'h1, 2'h0, 2'h1, 3'h1, 1'h1}, {3'h1, 2'h0, 2'h0, 3'h2, 1'h0},
        {3'h2, 2'h1, 2'h2, 3'h2, 1'h1}, {3'h3, 2'h2, 2'h0, 3'h1, 1'h1},
        {3'h3, 2'h0, 2'h0, 3'h4, 1'h0}, {3'h4, 2'h3, 2'h3, 3'h4, 1'h1},
        {3'h5, 2'h0, 2'h2, 3'h1, 1'h1}, {3'h6, 2'h1, 2'h0, 3'h4, 1'h1},
        {3'h7, 2'h2, 2'h1, 3'h2, 1'h1}, {3'h4, 2'h1, 2'h1, 3'h3, 1'h0}};
    fault_source_model src_u (.clk_sys(clk_sys), .reset_n(reset_n),
        .fault_cmd(fault_cmd), .comparator1_result(c1),
        .comparator2_result(c2), .fault_input_pin_n(flt_n), .pwm_a(pa),
        .pwm_b(pb), .pwm_c(pc), .pwm_d(pd), .period_start(pstart));
    pwm_fault_auto_shutdown dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comparator1_result(c1), .comparator2_result(c2),
        .fault_input_pin_n(flt_n), .pwm_a(pa), .pwm_b(pb), .pwm_c(pc),
        .pwm_d(pd), .period_start(pstart), .pwm_out_a(oa),
        .pwm_out_a_oe_n(oa_n), .pwm_out_b(ob), .pwm_out_b_oe_n(ob_n),
        .pwm_out_c(oc), .pwm_out_c_oe_n(oc_n), .pwm_out_d(od),
        .pwm_out_d_oe_n(od_n), .irq(irq));
    always #25 clk_sys = ~clk_sys;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; no wait-state count is assumed
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // tri-stated when tripped with state 1x, else driven to its level
    task automatic pin(input logic oe_n, input logic o, input logic [1:0] s,
        input logic trip, input logic raw_pwm);
        check(oe_n, trip && s[1]);
        if (!(trip && s[1])) check(o, trip ? s[0] : raw_pwm);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // watchdog: the run needs about 500 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        stop_test();
    end
    initial begin
        {clk_sys, reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        fault_cmd = 3'h0;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        // reset values, then an unmapped address
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            check(q, 32'h0);
            check(e, i == 4);
        end
        $display("test reset values done");
        foreach (rows[i]) begin
            r = rows[i];
            cfg = {1'b0, r[10:4]};
            apb(1'b1, 8'h00, {24'h0, cfg});
            fault_cmd <= r[3:1];
            repeat (8) @(posedge clk_sys);
            pin(oa_n, oa, r[7:6], r[0], pa);
            pin(oc_n, oc, r[7:6], r[0], pc);
            pin(ob_n, ob, r[5:4], r[0], pb);
            pin(od_n, od, r[5:4], r[0], pd);
            apb(1'b0, 8'h00, 32'h0);
            check(q[7], r[0]);
            fault_cmd <= 3'h0;
            repeat (4) @(posedge clk_sys);
            apb(1'b1, 8'h00, {24'h0, cfg});
            @(posedge clk_sys);
            pin(oa_n, oa, r[7:6], r[0], pa);
            pin(ob_n, ob, r[5:4], r[0], pb);
            repeat (11) @(posedge clk_sys);
            apb(1'b0, 8'h00, 32'h0);
            check({oa_n, q[7]}, 2'h0);
        end
        $display("test source table done");
        // clearing write refused while the fault level persists
        apb(1'b1, 8'h00, 32'h10);
        fault_cmd <= 3'h1;
        repeat (8) @(posedge clk_sys);
        apb(1'b1, 8'h00, 32'h10);
        apb(1'b0, 8'h00, 32'h0);
        check({q[7], oa}, 2'h2);
        $display("test refused clear done");
        // interrupt: sticky status, cleared by read, masked
        apb(1'b0, 8'h04, 32'h0);
        check(q[0], 1'b1);
        apb(1'b0, 8'h04, 32'h0);
        check(q[0], 1'b0);
        fault_cmd <= 3'h0;
        repeat (4) @(posedge clk_sys);
        apb(1'b1, 8'h00, 32'h10);
        apb(1'b0, 8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'h1);
        check(irq, 1'b0);
        fault_cmd <= 3'h1;
        repeat (8) @(posedge clk_sys);
        check(irq, 1'b1);
        apb(1'b0, 8'h04, 32'h0);
        @(posedge clk_sys);
        check({q[0], irq}, 2'h2);
        apb(1'b1, 8'h08, 32'h0);
        $display("test interrupt done");
        // auto-restart clears the flag once the fault is gone
        apb(1'b1, 8'h0C, 32'h1);
        fault_cmd <= 3'h0;
        repeat (14) @(posedge clk_sys);
        apb(1'b0, 8'h00, 32'h0);
        check(q[7:0], 8'h10);
        $display("test auto restart done");
        // reset in mid-shutdown
        fault_cmd <= 3'h1;
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check({oa_n, ob_n, irq}, 3'h0);
        reset_n <= 1'b1;
        fault_cmd <= 3'h0;
        apb(1'b0, 8'h00, 32'h0);
        check(q, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        check(q, 32'h0);
        $display("test second reset done");
        stop_test();
    end
endmodule
`default_nettype wire
